//--- hzr_pkg.sv
// constants, field layout and state codes for the zero-return pulse channel
// assumes a 200 MHz system clock and a 32-bit register port
package hzr_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned FILTER_MS = 10;
  localparam int unsigned FILTER_CYC_DEF = FILTER_MS * (CLK_HZ / 1000);
  localparam int unsigned CLEAR_MS = 20;
  localparam int unsigned CLEAR_CYC_DEF = CLEAR_MS * (CLK_HZ / 1000);
  localparam int unsigned SCAN_US = 1000;
  localparam int unsigned SCAN_CYC_DEF = SCAN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RAMP_NS = 1000;
  localparam int unsigned RAMP_CYC = RAMP_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int FREQ_W = 18;
  localparam int CREEP_W = 15;
  localparam int ACC_W = 28;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ABS_W = 3;
  localparam logic [ACC_W-1:0] HALF_CYCLE_HZ = ACC_W'(CLK_HZ / 2);
  localparam logic [FREQ_W-1:0] MIN_HZ = 18'h0000A;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ZR_SPEED = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CREEP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RAMP_STEP = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_POSITION = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ABS_VALUE = 8'h18;
  localparam int CTRL_ACT_BIT = 0;
  localparam int CTRL_CLR_EN_BIT = 1;
  localparam int CTRL_DOG_FAST_BIT = 2;
  localparam int CTRL_ABS_LSB = 4;
  localparam int STAT_REJ_BIT = 3;
  localparam logic [FREQ_W-1:0] ZR_SPEED_RST = 18'h003E8;
  localparam logic [CREEP_W-1:0] CREEP_RST = 15'h0064;
  localparam logic [FREQ_W-1:0] RAMP_STEP_RST = 18'h00064;
  localparam logic [DATA_W-1:0] POS_RST = 32'h00000000;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FAST = 6'h02,
    ST_SLOW = 6'h04,
    ST_DECEL = 6'h08,
    ST_CLR = 6'h10,
    ST_FIN = 6'h20
  } hzr_state_t;

endpackage

//--- hzr_pg_if.sv
// rate and pulse handshake between the homing sequencer and the pulse generator
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface hzr_pg_if import hzr_pkg::*; ();
  logic [FREQ_W-1:0] freq;
  logic run;
  logic level;
  logic step;
  modport ctl (output freq, output run, input level, input step);
  modport gen (input freq, input run, output level, output step);
endinterface
`default_nettype wire

//--- hzr_pulse_gen.sv
// square-wave pulse generator with a phase accumulator, one step per rising edge
// assumes freq is at most half the clock rate and run is driven from a flop
`timescale 1ns/1ps
`default_nettype none
module hzr_pulse_gen import hzr_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  hzr_pg_if.gen pg
);

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] acc;
  wire [ACC_W-1:0] acc_sum = acc + ACC_W'(pg.freq);
  wire acc_wrap = acc_sum >= HALF_CYCLE_HZ;

  // dropping run clears the wave at once: no tail, no ramp
  always_ff @(posedge clock) begin
    if (!nrst || !pg.run) begin
      acc <= '0;
      pg.level <= 1'b0;
      pg.step <= 1'b0;
    end else if (acc_wrap) begin
      acc <= acc_sum - HALF_CYCLE_HZ;
      pg.level <= ~pg.level;
      pg.step <= ~pg.level;
    end else begin
      acc <= acc_sum;
      pg.step <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  cut_no_tail_a: assert property (@(posedge clock) disable iff (!nrst)
    !pg.run |=> !pg.level && !pg.step)
    else $error("pulse train continued after run dropped");

  step_on_rise_a: assert property (@(posedge clock) disable iff (!nrst)
    pg.step |-> pg.level && !$past(pg.level))
    else $error("step without a rising pulse edge");

endmodule
`default_nettype wire

//--- hzr_homing.sv
// zero-return sequencer for one pulse output channel with register port
// assumes a single clock; dog, limit and absolute-data inputs are asynchronous pins
//
// Operation
// - dog front slows to creep, rear stops
// - clear current position to zero after stop
// - stop at creep with no ramp
// - fast dog input stops without scan delay
// - other dog inputs go through filter, scan
// - activation release decelerates then stops
// - release end leaves done flag cleared
// - reject new command while channel busy
// - limit flag decelerates, stops, flags abnormal
// - opposite-side limit also aborts with abnormal
// - absolute read takes three input points
// - absolute read drives three output points
// - absolute value stored as one 32-bit word
// - run at zero-return speed until dog
// - reverse travel, position counts down
// - clear pulse within 1 ms, 20 ms plus scan
// - done flag set after position clear
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hzr_homing import hzr_pkg::*; #(
  parameter int unsigned FILTER_CYC = FILTER_CYC_DEF,
  parameter int unsigned CLEAR_CYC = CLEAR_CYC_DEF,
  parameter int unsigned SCAN_CYC = SCAN_CYC_DEF
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic dog_in,
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic [ABS_W-1:0] abs_data_in,
  output logic [ABS_W-1:0] abs_ctl_out,
  output logic pulse_out,
  output logic clear_out,
  output logic busy_out
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_ctrl = wr & hit(addr, OFS_CTRL);
  wire wr_zr = wr & hit(addr, OFS_ZR_SPEED);
  wire wr_creep = wr & hit(addr, OFS_CREEP);
  wire wr_step = wr & hit(addr, OFS_RAMP_STEP);
  wire wr_status = wr & hit(addr, OFS_STATUS);
  wire wr_pos = wr & hit(addr, OFS_POSITION);
  wire wr_abs = wr & hit(addr, OFS_ABS_VALUE);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic act;
  logic clr_en;
  logic dog_fast;
  logic [FREQ_W-1:0] zr_speed;
  logic [CREEP_W-1:0] creep;
  logic [FREQ_W-1:0] ramp_step;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      act <= 1'b0;
      clr_en <= 1'b0;
      dog_fast <= 1'b0;
      abs_ctl_out <= '0;
    end else if (wr_ctrl) begin
      act <= wdata[CTRL_ACT_BIT];
      clr_en <= wdata[CTRL_CLR_EN_BIT];
      dog_fast <= wdata[CTRL_DOG_FAST_BIT];
      abs_ctl_out <= wdata[CTRL_ABS_LSB +: ABS_W];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      zr_speed <= ZR_SPEED_RST;
      creep <= CREEP_RST;
      ramp_step <= RAMP_STEP_RST;
    end else begin
      if (wr_zr) zr_speed <= wdata[FREQ_W-1:0];
      if (wr_creep) creep <= wdata[CREEP_W-1:0];
      if (wr_step) ramp_step <= wdata[FREQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [ABS_W+2:0] sync1;
  logic [ABS_W+2:0] sync2;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {abs_data_in, rev_limit_in, fwd_limit_in, dog_in};
      sync2 <= sync1;
    end
  end

  wire dog_s2 = sync2[0];
  wire limit_any = sync2[1] | sync2[2];
  wire [ABS_W-1:0] abs_s2 = sync2[3 +: ABS_W];

  // ----------------------------------------------------------------
  // dog qualification: direct path or filter plus scan sampling
  // ----------------------------------------------------------------
  logic dog_filt;
  logic dog_scan;
  logic dog_prev;
  logic [CNT_W-1:0] filt_cnt;
  logic [CNT_W-1:0] scan_cnt;
  wire scan_tick = scan_cnt == CNT_W'(SCAN_CYC - 1);
  wire filt_full = filt_cnt == CNT_W'(FILTER_CYC - 1);
  // the direct path skips filter and scan so the stop tracks the dog edge
  wire dog_eff = dog_fast ? dog_s2 : dog_scan;
  wire dog_rise = dog_eff & ~dog_prev;
  wire dog_fall = ~dog_eff & dog_prev;

  // a level must hold for the whole filter time before it is accepted
  always_ff @(posedge clock) begin
    if (!nrst || dog_s2 == dog_filt) begin
      filt_cnt <= '0;
    end else if (filt_full) begin
      filt_cnt <= '0;
    end else begin
      filt_cnt <= filt_cnt + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      dog_filt <= 1'b0;
      dog_scan <= 1'b0;
      dog_prev <= 1'b0;
      scan_cnt <= '0;
    end else begin
      if (dog_s2 != dog_filt && filt_full) dog_filt <= dog_s2;
      if (scan_tick) dog_scan <= dog_filt;
      dog_prev <= dog_eff;
      scan_cnt <= scan_tick ? '0 : scan_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  hzr_state_t state;
  hzr_state_t next_state;
  logic act_prev;
  logic [CNT_W-1:0] ramp_cnt;
  logic [CNT_W-1:0] clr_cnt;
  logic [FREQ_W-1:0] cur_freq;
  logic abn_pend;
  logic fin_ok;
  logic done;
  logic abnormal;
  logic rejected;
  logic [DATA_W-1:0] position;

  hzr_pg_if pg ();

  wire busy = state != ST_IDLE;
  wire act_rise = act & ~act_prev;
  wire start = ~busy & act_rise;
  wire in_motion = state == ST_FAST || state == ST_SLOW;
  wire abort = ~act | limit_any;
  wire home_stop = state == ST_SLOW && !abort && dog_fall;
  wire ramp_tick = ramp_cnt == CNT_W'(RAMP_CYC - 1);
  wire clr_end = clr_cnt == CNT_W'(CLEAR_CYC + SCAN_CYC - 1);
  wire [FREQ_W-1:0] eff_step = (ramp_step == '0) ? 18'h00001 : ramp_step;
  wire [FREQ_W:0] cur_x = {1'b0, cur_freq};
  wire [FREQ_W:0] creep_x = {4'h0, creep};
  wire [FREQ_W:0] creep_lim = creep_x + {1'b0, eff_step};
  wire [FREQ_W:0] min_lim = {1'b0, MIN_HZ} + {1'b0, eff_step};
  wire [FREQ_W-1:0] slow_down = (cur_x > creep_lim) ? cur_freq - eff_step
                                                    : creep_x[FREQ_W-1:0];
  wire [FREQ_W-1:0] dec_down = (cur_x > min_lim) ? cur_freq - eff_step : MIN_HZ;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (act_rise) next_state = ST_FAST;
      ST_FAST: next_state = abort ? ST_DECEL : dog_rise ? ST_SLOW : ST_FAST;
      ST_SLOW: begin
        if (abort) next_state = ST_DECEL;
        else if (dog_fall) next_state = clr_en ? ST_CLR : ST_FIN;
      end
      ST_DECEL: if (ramp_tick && cur_freq == MIN_HZ) next_state = ST_FIN;
      ST_CLR: if (clr_end) next_state = ST_FIN;
      ST_FIN: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // speed profile: full speed, ramp to creep after the dog, ramp to minimum on abort
  wire [FREQ_W-1:0] next_freq =
    (start || state == ST_FAST) ? zr_speed :
    (state == ST_SLOW && ramp_tick) ? slow_down :
    (state == ST_DECEL && ramp_tick) ? dec_down : cur_freq;

  assign pg.freq = cur_freq;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= ST_IDLE;
      act_prev <= 1'b0;
      cur_freq <= MIN_HZ;
      pg.run <= 1'b0;
      ramp_cnt <= '0;
      clr_cnt <= '0;
    end else begin
      state <= next_state;
      act_prev <= act;
      cur_freq <= next_freq;
      // a stop at the dog rear drops run with no ramp
      pg.run <= next_state == ST_FAST || next_state == ST_SLOW
                || next_state == ST_DECEL;
      ramp_cnt <= (ramp_tick || !busy) ? '0 : ramp_cnt + 1'b1;
      clr_cnt <= (state == ST_CLR) ? clr_cnt + 1'b1 : '0;
    end
  end

  hzr_pulse_gen u_gen (
    .clock(clock),
    .nrst(nrst),
    .pg(pg.gen)
  );

  // ----------------------------------------------------------------
  // completion flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst || start) begin
      abn_pend <= 1'b0;
      fin_ok <= 1'b0;
      done <= 1'b0;
      abnormal <= 1'b0;
    end else begin
      if ((in_motion || state == ST_DECEL) && limit_any) abn_pend <= 1'b1;
      if (home_stop) fin_ok <= 1'b1;
      if (state == ST_FIN) begin
        done <= fin_ok;
        abnormal <= abn_pend;
      end
    end
  end

  // a new command on a busy channel is dropped and remembered; set beats clear
  always_ff @(posedge clock) begin
    if (!nrst) rejected <= 1'b0;
    else if (busy && act_rise) rejected <= 1'b1;
    else if (wr_status && wdata[STAT_REJ_BIT]) rejected <= 1'b0;
  end

  // ----------------------------------------------------------------
  // position counter and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) position <= POS_RST;
    else if (home_stop) position <= '0;
    else if (wr_abs) position <= wdata;
    else if (wr_pos) position <= wdata;
    else if (pg.step) position <= position - 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pulse_out <= 1'b0;
      clear_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      pulse_out <= pg.level;
      clear_out <= next_state == ST_CLR;
      busy_out <= next_state != ST_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // read port: data only in the cycle after the strobe
  // ----------------------------------------------------------------
  wire [DATA_W-1:0] rd_ctrl = {25'h0000000, abs_ctl_out, 1'b0, dog_fast, clr_en, act};
  wire [DATA_W-1:0] rd_status = {24'h000000, dog_eff, abs_s2, rejected, busy,
                                 abnormal, done};
  wire [DATA_W-1:0] rd_mux =
    hit(addr, OFS_CTRL) ? rd_ctrl :
    hit(addr, OFS_ZR_SPEED) ? {14'h0000, zr_speed} :
    hit(addr, OFS_CREEP) ? {17'h00000, creep} :
    hit(addr, OFS_RAMP_STEP) ? {14'h0000, ramp_step} :
    hit(addr, OFS_STATUS) ? rd_status :
    hit(addr, OFS_POSITION) ? position : 32'h00000000;

  always_ff @(posedge clock) begin
    if (!nrst) rdata <= '0;
    else rdata <= rd ? rd_mux : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  dog_rear_stop_a: assert property (@(posedge clock) disable iff (!nrst)
    home_stop |=> !pg.run ##1 !pg.level)
    else $error("pulses not cut at dog rear");
  dog_front_slow_a: assert property (@(posedge clock) disable iff (!nrst)
    state == ST_FAST && !abort && dog_rise |=> state == ST_SLOW)
    else $error("dog front did not start slowdown");
  pos_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    home_stop |=> position == 32'h00000000)
    else $error("position not cleared at stop");
  fast_dog_a: assert property (@(posedge clock) disable iff (!nrst)
    dog_fast && $past(dog_fast) && state == ST_SLOW && !abort && $fell(dog_s2)
    |=> !pg.run)
    else $error("direct dog edge did not stop at once");
  filter_time_a: assert property (@(posedge clock) disable iff (!nrst)
    $changed(dog_filt) |-> $past(filt_full) && $past(dog_s2) != $past(dog_filt))
    else $error("dog filter accepted a short level");
  release_decel_a: assert property (@(posedge clock) disable iff (!nrst)
    in_motion && !act |=> state == ST_DECEL ##1 pg.run)
    else $error("release did not decelerate");
  release_no_done_a: assert property (@(posedge clock) disable iff (!nrst)
    state == ST_FIN && !fin_ok |=> !done)
    else $error("done set after aborted homing");
  busy_reject_a: assert property (@(posedge clock) disable iff (!nrst)
    busy && act_rise |=> rejected && (state != ST_FAST || $past(state) == ST_FAST))
    else $error("command accepted on busy channel");
  limit_abn_a: assert property (@(posedge clock) disable iff (!nrst)
    in_motion && limit_any |=> state == ST_DECEL && abn_pend)
    else $error("limit did not abort with abnormal pending");
  abn_flag_a: assert property (@(posedge clock) disable iff (!nrst)
    state == ST_FIN |=> abnormal == $past(abn_pend) && done == $past(fin_ok))
    else $error("completion flags wrong at finish");
  abs_word_a: assert property (@(posedge clock) disable iff (!nrst)
    wr_abs && !home_stop |=> position == $past(wdata))
    else $error("absolute value not stored whole");
  rev_count_a: assert property (@(posedge clock) disable iff (!nrst)
    pg.step && !home_stop && !wr_abs && !wr_pos |=> position == $past(position) - 1)
    else $error("position not counted down");
  zr_speed_a: assert property (@(posedge clock) disable iff (!nrst)
    state == ST_FAST |-> cur_freq == zr_speed)
    else $error("not at zero-return speed before dog");
  clear_on_a: assert property (@(posedge clock) disable iff (!nrst)
    home_stop && clr_en |=> ##1 clear_out)
    else $error("clear output late");

  cov_home_c: cover property (@(posedge clock) disable iff (!nrst)
    state == ST_FIN && fin_ok);
  cov_release_c: cover property (@(posedge clock) disable iff (!nrst)
    in_motion && !act && !limit_any);
  cov_limit_c: cover property (@(posedge clock) disable iff (!nrst)
    in_motion && limit_any);
  cov_reject_c: cover property (@(posedge clock) disable iff (!nrst)
    busy && act_rise);

endmodule
`default_nettype wire

//--- hzr_servo_model.sv
// servo amplifier with near-point dog, standing on the far side of the pulse channel
// assumes one clock shared with the channel and a registered pulse_out square wave
`timescale 1ns/1ps
`default_nettype none
module hzr_servo_model import hzr_pkg::*; (
  input wire logic clock,
  input wire logic nrst,
  input wire logic pulse_out,
  input wire logic [ABS_W-1:0] abs_ctl_out,
  input wire logic cnt_clr,
  input wire logic [31:0] dog_at,
  input wire logic [31:0] dog_len,
  output logic dog_in,
  output logic [ABS_W-1:0] abs_data_in,
  output logic [31:0] pulses
);
  // ----------------------------------------------------------------
  // travel and dog window
  // ----------------------------------------------------------------
  logic last;
  // answer lines are the control lines rotated, so a swapped point shows
  assign abs_data_in = {abs_ctl_out[1:0], abs_ctl_out[2]};
  // counting restarts at zero on the approach side, before the dog
  // the window is long enough in pulses to reach creep first
  // the dog line feeds only the near-point pin, no other function shares it
  assign dog_in = (pulses >= dog_at) && (pulses < dog_at + dog_len);
  always_ff @(posedge clock) begin
    last <= pulse_out;
    if (!nrst || cnt_clr) begin
      pulses <= 32'h0;
    end else if (pulse_out && !last) begin
      pulses <= pulses + 32'h1;
    end
  end
endmodule
`default_nettype wire

//--- test_dog_zero_return_pulse_output.sv
// self-checking bench for the zero-return pulse channel and its register port
// assumes hzr_pkg, the pulse generator, the sequencer and the servo model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_dog_zero_return_pulse_output;
  import hzr_pkg::*;
  localparam int unsigned FILT = 4;
  localparam int unsigned CLR = 8;
  localparam int unsigned SCAN = 5;
  logic clock, nrst, wr, rd, fwd_limit_in, rev_limit_in, cnt_clr;
  logic dog_in, pulse_out, clear_out, busy_out;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv;
  logic [ABS_W-1:0] abs_data_in, abs_ctl_out;
  logic [31:0] dog_at, dog_len, pulses, snap, target;
  logic [2:0] v;
  int mismatches, checks, n;
  logic [7:0] ra [8] = '{OFS_CTRL, OFS_ZR_SPEED, OFS_CREEP, OFS_RAMP_STEP, OFS_STATUS,
    OFS_POSITION, OFS_ABS_VALUE, 8'h1C};
  logic [31:0] re [8] = '{32'h0, 32'(ZR_SPEED_RST), 32'(CREEP_RST), 32'(RAMP_STEP_RST),
    32'h0, POS_RST, 32'h0, 32'h0};

  hzr_homing #(.FILTER_CYC(FILT), .CLEAR_CYC(CLR), .SCAN_CYC(SCAN)) dut (.clock(clock),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .dog_in(dog_in), .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
    .abs_data_in(abs_data_in), .abs_ctl_out(abs_ctl_out), .pulse_out(pulse_out),
    .clear_out(clear_out), .busy_out(busy_out));
  hzr_servo_model servo (.clock(clock), .nrst(nrst), .pulse_out(pulse_out),
    .abs_ctl_out(abs_ctl_out), .cnt_clr(cnt_clr), .dog_at(dog_at), .dog_len(dog_len),
    .dog_in(dog_in), .abs_data_in(abs_data_in), .pulses(pulses));

  // ----------------------------------------------------------------
  // bus access, comparison and bounded waits
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (mismatches == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask
  // the bound doubles as a latency limit; running out of it ends the run
  task automatic wait_on(input int sel, input logic lvl, input int bound);
    logic s;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
      case (sel)
        0: s = busy_out;
        1: s = dog_in;
        2: s = clear_out;
        default: s = (pulses >= target);
      endcase
    end while (s !== lvl && n < bound);
    if (s !== lvl) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic start(input logic [31:0] ctrl, input logic [31:0] at);
    wr_reg(OFS_CTRL, 32'h0);
    wr_reg(OFS_ABS_VALUE, 32'h100);
    cnt_clr <= 1'b1;
    dog_at <= at;
    @(posedge clock);
    cnt_clr <= 1'b0;
    wr_reg(OFS_CTRL, ctrl);
    wait_on(0, 1'b1, 10);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic home(input logic [31:0] ctrl);
    start(ctrl, 32'h4);
    target = 32'h1;
    wait_on(3, 1'b1, 2000);
    target = 32'h2;
    wait_on(3, 1'b1, 2000);
    check("zero return period", 32'h1, 32'(n >= 995 && n <= 1005));
    wait_on(1, 1'b1, 10000);
    wait_on(1, 1'b0, 40000);
    snap = pulses;
    if (ctrl[CTRL_CLR_EN_BIT]) begin
      wait_on(2, 1'b1, 8);
      wait_on(2, 1'b0, 40);
      check("clear hold", CLR + SCAN, 32'(n));
    end
    wait_on(0, 1'b0, 100);
    if (!ctrl[CTRL_DOG_FAST_BIT])
      check("filter delay", 32'h1, 32'(n >= 2 + FILT && n <= 4 + FILT + SCAN));
    check("pulses after dog", snap, pulses);
    check("clear idle", 32'h0, 32'(clear_out));
    rd_reg(OFS_POSITION);
    check("position cleared", 32'h0, rv);
    rd_reg(OFS_STATUS);
    check("done flags", 32'h1, rv & 32'hF);
  endtask
  // kind 0 releases activation and restarts it while busy, 1 and 2 raise a limit
  task automatic abort_run(input int kind);
    start(32'h1, 32'hFFFF);
    target = 32'h2;
    wait_on(3, 1'b1, 4000);
    if (kind == 0) begin
      wr_reg(OFS_CTRL, 32'h0);
      wr_reg(OFS_CTRL, 32'h1);
    end else begin
      @(posedge clock);
      fwd_limit_in <= (kind == 1);
      rev_limit_in <= (kind == 2);
    end
    wait_on(0, 1'b0, 2000);
    fwd_limit_in <= 1'b0;
    rev_limit_in <= 1'b0;
    rd_reg(OFS_POSITION);
    check("position count", 32'h100 - pulses, rv);
    rd_reg(OFS_STATUS);
    check("abort flags", (kind == 0) ? 32'h8 : 32'h2, rv & 32'hF);
    wr_reg(OFS_STATUS, 32'h8);
    rd_reg(OFS_STATUS);
    check("rejected cleared", 32'h0, rv & 32'h8);
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    {nrst, wr, rd, fwd_limit_in, rev_limit_in, cnt_clr} = '0;
    addr = '0;
    wdata = '0;
    dog_at = 32'h4;
    dog_len = 32'h3;
    target = 32'h0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd_reg(ra[i]);
      check("reset value", re[i], rv);
    end
    wr_reg(OFS_ABS_VALUE, 32'hA5C3_0F96);
    rd_reg(OFS_POSITION);
    check("absolute load", 32'hA5C3_0F96, rv);
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      wr_reg(OFS_CTRL, 32'(v) << CTRL_ABS_LSB);
      repeat (3) @(posedge clock);
      check("abs control", 32'(v), 32'(abs_ctl_out));
      rd_reg(OFS_STATUS);
      check("abs input", 32'({v[1:0], v[2]}), (rv >> 4) & 32'h7);
    end
    wr_reg(OFS_ZR_SPEED, 32'h0003_0D40);
    wr_reg(OFS_CREEP, 32'h0000_7D00);
    wr_reg(OFS_RAMP_STEP, 32'h0003_FFFF);
    rd_reg(OFS_ZR_SPEED);
    check("speed readback", 32'h0003_0D40, rv);
    home(32'h7);
    home(32'h1);
    for (int k = 0; k < 3; k++) begin
      abort_run(k);
    end
    complete_run();
  end
endmodule
`default_nettype wire
